/* File: src/icrs_pkg.sv */
package icrs_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS     = 50;
  localparam int IDLE_TIME_NS      = 1000;   // no-transition interval before refresh
  localparam int WDOG_TIME_NS      = 5000;   // silence before output forced to default
  localparam int SHUTDOWN_TIME_US  = 2000;   // hiccup off time
  // least times round up, longest round down
  localparam int IDLE_CYCLES       = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDOG_CYCLES       = WDOG_TIME_NS / CLK_PERIOD_NS;
  localparam int SHUTDOWN_CYCLES   = (SHUTDOWN_TIME_US * 1000) / CLK_PERIOD_NS;
  // ************************************************************
  // converter
  // ************************************************************
  localparam int PWM_WIDTH         = 8;
  localparam int SOFT_STEP_CYCLES  = 16;     // cycles between soft-start duty increments
  localparam int DEFAULT_OUT       = 0;      // watchdog and lockout default level
  // pulse encoding on the barrier
  typedef enum logic [1:0] {ICRS_PULSE_NONE, ICRS_PULSE_RISE, ICRS_PULSE_FALL} icrs_pulse_type;
  typedef enum logic [1:0] {ICRS_OFF, ICRS_SOFT, ICRS_NORMAL, ICRS_SHUTDOWN} icrs_conv_type;
endpackage

/* File: src/icrs_channel.sv */
`timescale 1ns/1ps
// one isolated channel: encoder on the input side, bistable decoder on the output side
module icrs_channel
  import icrs_pkg::*;
#(
  parameter int IDLE_CNT = IDLE_CYCLES,
  parameter int WDOG_CNT = WDOG_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic in_side_ok_i,
  input  wire logic out_side_ok_i,
  input  wire logic data_i,
  output logic      data_o
);
  // ************************************************************
  // encoder
  // ************************************************************
  logic            last_in;
  logic [15:0]     idle_cnt;
  logic [1:0]      pulse;
  wire logic       edge_seen  = in_side_ok_i && (data_i != last_in);
  wire logic       refresh_due = in_side_ok_i && (idle_cnt >= 16'(IDLE_CNT - 1));
  wire logic [1:0] next_pulse = !(edge_seen || refresh_due) ? ICRS_PULSE_NONE :
                                data_i ? ICRS_PULSE_RISE : ICRS_PULSE_FALL;

  // edge pulses and idle refresh; lockout keeps the driver quiet
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !in_side_ok_i) begin
      last_in  <= 1'b0;
      idle_cnt <= '0;
      pulse    <= ICRS_PULSE_NONE;
    end else begin
      last_in  <= data_i;
      pulse    <= next_pulse;
      idle_cnt <= (edge_seen || refresh_due) ? '0 : idle_cnt + 16'h0001;
    end
  end

  // ************************************************************
  // decoder and watchdog
  // ************************************************************
  logic        state;
  logic [15:0] wdog_cnt;
  wire logic   got_pulse = (pulse != ICRS_PULSE_NONE);
  wire logic   wdog_hit  = (wdog_cnt >= 16'(WDOG_CNT - 1));

  // bistable: set by rise, clear by fall, forced low on silence or lockout
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !out_side_ok_i) begin
      state    <= 1'(DEFAULT_OUT);
      wdog_cnt <= '0;
    end else if (got_pulse) begin
      state    <= (pulse == ICRS_PULSE_RISE);
      wdog_cnt <= '0;
    end else if (wdog_hit) begin
      state    <= 1'(DEFAULT_OUT);
    end else begin
      wdog_cnt <= wdog_cnt + 16'h0001;       // count up until timeout, then hold
    end
  end
  assign data_o = state;

  a_wdog_default: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    out_side_ok_i && wdog_hit && !got_pulse |=> !state)
    else $error("watchdog did not force default");
  a_rise_sets: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    out_side_ok_i && pulse == ICRS_PULSE_RISE |=> state)
    else $error("rise pulse did not set output");
endmodule // icrs_channel

/* File: src/icrs_top.sv */
`timescale 1ns/1ps
// What this block does
// - each input edge sends one pulse, rise and fall distinct.
// - output latch set by rise pulse, cleared by fall pulse, holds.
// - idle input beyond 1 us sends periodic refresh of its level.
// - no pulse for about 5 us forces output to default.
// - at power-up converter soft-starts, widening pulse gradually.
// - output above start threshold hands width to secondary feedback.
// - short circuit stops switching about 2 ms, then soft start.
// - fault still present after soft start repeats; cleared goes normal.
// - peak switch current ends the present pulse, each cycle.
// - under primary lockout, oscillator stopped, drivers idle, primary outputs low.
// - primary idle until its supply good; its outputs start low.
// - primary inputs send pulses once released, secondary maybe dead.
// - secondary outputs start low until a pulse arrives.
// - secondary outputs track inputs within about 1 us.
// - on primary loss outputs hold, then default on watchdog or lockout.
module icrs_top
  import icrs_pkg::*;
#(
  parameter int NCH          = 4,
  parameter int SHUTDOWN_CNT = SHUTDOWN_CYCLES,
  parameter int PWM_MAX      = 200
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 primary_supply_ok_i,
  input  wire logic                 iso_supply_ok_i,
  input  wire logic                 iso_above_start_i,
  input  wire logic                 short_circuit_i,
  input  wire logic                 peak_current_i,
  input  wire logic [PWM_WIDTH-1:0] feedback_duty_i,
  input  wire logic [NCH-1:0]       fwd_data_i,
  input  wire logic [NCH-1:0]       rev_data_i,
  output logic      [NCH-1:0]       fwd_data_o,
  output logic      [NCH-1:0]       rev_data_o,
  output logic                      primary_switch_a_o,
  output logic                      primary_switch_b_o,
  output logic      [1:0]           conv_mode_o
);
  // ************************************************************
  // channels
  // ************************************************************
  logic [NCH-1:0] fwd_raw;
  logic [NCH-1:0] rev_raw;
  // forward: primary to secondary; reverse: secondary to primary
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    icrs_channel u_fwd (
      .ref_clk_i    (ref_clk_i),
      .reset_i      (reset_i),
      .in_side_ok_i (primary_supply_ok_i),
      .out_side_ok_i(iso_supply_ok_i),
      .data_i       (fwd_data_i[g]),
      .data_o       (fwd_raw[g])
    );
    icrs_channel u_rev (
      .ref_clk_i    (ref_clk_i),
      .reset_i      (reset_i),
      .in_side_ok_i (iso_supply_ok_i),
      .out_side_ok_i(primary_supply_ok_i),
      .data_i       (rev_data_i[g]),
      .data_o       (rev_raw[g])
    );
  end
  // outputs registered once more, forced low under lockout
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      fwd_data_o <= '0;
      rev_data_o <= '0;
    end else begin
      fwd_data_o <= iso_supply_ok_i ? fwd_raw : '0;
      rev_data_o <= primary_supply_ok_i ? rev_raw : '0;
    end
  end

  // ************************************************************
  // converter sequencer
  // ************************************************************
  icrs_conv_type             mode;
  logic [31:0]               timer;
  logic [PWM_WIDTH-1:0]      soft_duty;
  logic [PWM_WIDTH-1:0]      phase;
  logic                      half;       // alternates the two switches
  logic                      cut;        // pulse ended by current limit
  wire logic [PWM_WIDTH-1:0] pwm_max_w  = PWM_WIDTH'(PWM_MAX);
  wire logic                 soft_done  = (soft_duty >= pwm_max_w);
  wire logic                 step_due   = (timer >= 32'(SOFT_STEP_CYCLES - 1));
  wire logic                 off_done   = (timer >= 32'(SHUTDOWN_CNT - 1));
  wire logic [PWM_WIDTH-1:0] duty       = (mode == ICRS_NORMAL) ? feedback_duty_i : soft_duty;
  wire logic                 switching  = (mode == ICRS_SOFT) || (mode == ICRS_NORMAL);
  wire logic                 phase_wrap = (phase == {PWM_WIDTH{1'b1}});
  wire logic                 drive_on   = switching && (phase < duty) && !cut && !peak_current_i;

  // mode machine: soft start, normal, hiccup shutdown
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !primary_supply_ok_i) begin
      mode      <= ICRS_OFF;
      timer     <= '0;
      soft_duty <= '0;
    end else begin
      unique case (mode)
        ICRS_OFF: begin
          mode <= ICRS_SOFT;
        end
        ICRS_SOFT: begin
          timer <= step_due ? '0 : timer + 32'h1;
          if (step_due && !soft_done) soft_duty <= soft_duty + PWM_WIDTH'(1);
          if (iso_above_start_i && !short_circuit_i) begin
            mode <= ICRS_NORMAL;
          end else if (soft_done && short_circuit_i) begin
            mode <= ICRS_SHUTDOWN;
            timer <= '0;
          end
        end
        ICRS_NORMAL: begin
          if (short_circuit_i) begin
            mode  <= ICRS_SHUTDOWN;
            timer <= '0;
          end
        end
        ICRS_SHUTDOWN: begin
          timer <= timer + 32'h1;
          if (off_done) begin
            mode      <= ICRS_SOFT;
            timer     <= '0;
            soft_duty <= '0;
          end
        end
      endcase
    end
  end

  // oscillator and push-pull drive; peak current cuts the pulse
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !primary_supply_ok_i) begin
      phase              <= '0;              // oscillator stopped
      half               <= 1'b0;
      cut                <= 1'b0;
      primary_switch_a_o <= 1'b0;
      primary_switch_b_o <= 1'b0;
    end else begin
      phase              <= switching ? phase + PWM_WIDTH'(1) : '0;
      half               <= (switching && phase_wrap) ? !half : half;
      cut                <= (phase_wrap || !switching) ? 1'b0 : (cut | peak_current_i);
      primary_switch_a_o <= drive_on && !half;
      primary_switch_b_o <= drive_on && half;
    end
  end
  assign conv_mode_o = mode;

  // ************************************************************
  // checks: outputs under lockout
  // ************************************************************
  // each direction reads low while its output side is unpowered
  a_lockout_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !iso_supply_ok_i |=> fwd_data_o == '0)
    else $error("output not low under lockout");
  a_rev_lockout: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !primary_supply_ok_i |=> rev_data_o == '0)
    else $error("primary output not low under lockout");
  // under lockout the oscillator is stopped and the mode held off
  a_off_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !primary_supply_ok_i |=> mode == ICRS_OFF && phase == '0)
    else $error("oscillator ran under lockout");

  // ************************************************************
  // checks: soft start and regulation
  // ************************************************************
  // a good supply always starts with soft start, never straight into regulation
  a_off_to_soft: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_OFF && primary_supply_ok_i |=> mode == ICRS_SOFT)
    else $error("no soft start after supply good");
  // width only grows, and by one step at a time, to limit inrush
  a_soft_growth: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_SOFT && $past(mode) == ICRS_SOFT |-> soft_duty >= $past(soft_duty))
    else $error("soft start width shrank");
  a_soft_step: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_SOFT && $past(mode) == ICRS_SOFT
    |-> {1'b0, soft_duty} <= {1'b0, $past(soft_duty)} + 9'h001)
    else $error("soft start width jumped");
  a_soft_width: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_SOFT && phase >= soft_duty
    |=> !primary_switch_a_o && !primary_switch_b_o)
    else $error("switch on beyond soft start width");
  a_soft_handover: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_SOFT && iso_above_start_i && !short_circuit_i && primary_supply_ok_i
    |=> mode == ICRS_NORMAL)
    else $error("no handover to normal");
  // in normal mode the secondary's duty, not the soft start width, bounds the on-time
  a_normal_width: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_NORMAL && phase >= feedback_duty_i
    |=> !primary_switch_a_o && !primary_switch_b_o)
    else $error("switch on beyond feedback width");

  // ************************************************************
  // checks: short circuit and current limit
  // ************************************************************
  // the limit acts at once, and a cut pulse stays off to the period end
  a_peak_cuts: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    peak_current_i |=> !primary_switch_a_o && !primary_switch_b_o)
    else $error("switch stayed on at peak current");
  a_cut_holds: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    cut |=> !primary_switch_a_o && !primary_switch_b_o)
    else $error("cut pulse restarted in its period");
  a_short_stop: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_NORMAL && short_circuit_i && primary_supply_ok_i
    |=> mode == ICRS_SHUTDOWN ##1 !primary_switch_a_o && !primary_switch_b_o)
    else $error("short did not stop switching");
  a_shutdown_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_SHUTDOWN |=> !primary_switch_a_o && !primary_switch_b_o)
    else $error("switching during hiccup off time");
  // off time over: back to soft start from zero width
  a_hiccup_restart: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_SHUTDOWN && off_done && primary_supply_ok_i
    |=> mode == ICRS_SOFT && soft_duty == '0)
    else $error("no soft start after hiccup off time");
  // a short still there at full soft width sends the loop round again
  a_soft_to_off: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode == ICRS_SOFT && soft_done && short_circuit_i && primary_supply_ok_i
    |=> mode == ICRS_SHUTDOWN)
    else $error("short at soft start end not shut down");

  // main scenarios
  c_normal: cover property (@(posedge ref_clk_i) mode == ICRS_NORMAL);
  c_hiccup: cover property (@(posedge ref_clk_i) mode == ICRS_SHUTDOWN ##1 mode == ICRS_SOFT);
  c_cut: cover property (@(posedge ref_clk_i) switching && peak_current_i);
  c_soft_done: cover property (@(posedge ref_clk_i) mode == ICRS_SOFT && soft_done);
  c_soft_short: cover property (@(posedge ref_clk_i) mode == ICRS_SOFT ##1 mode == ICRS_SHUTDOWN);
endmodule // icrs_top

/* File: test/icrs_iso_model.sv */
`timescale 1ns/1ps
// ****************************************
// isolated side stand-in: rail, threshold, load short
// ****************************************
module icrs_iso_model #(
  parameter int DELAY = 4
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic charge_i,
  input  wire logic short_i,
  output logic      iso_supply_ok_o,
  output logic      iso_above_start_o,
  output logic      short_circuit_o
);
  int unsigned level;
  // rail climbs one step a cycle; a short collapses it at once
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !charge_i || short_i) begin
      level <= 0;
    end else if (level < 2 * DELAY) begin
      level <= level + 1;
    end
  end
  assign iso_supply_ok_o   = (level >= DELAY);
  assign iso_above_start_o = (level >= 2 * DELAY) && !short_i;
  assign short_circuit_o   = short_i;
endmodule // icrs_iso_model

/* File: test/icrs_top_tb.sv */
`timescale 1ns/1ps
module icrs_top_tb;
  import icrs_pkg::*;
  logic                 ref_clk_i = 1'b0;
  logic                 reset_i   = 1'b1;
  logic                 prim_ok   = 1'b0;
  logic                 iso_en    = 1'b0;
  logic                 short_req = 1'b0;
  logic                 peak      = 1'b0;
  logic [7:0]           duty      = 8'h00;
  logic [3:0]           fwd_in    = 4'h0;
  logic [3:0]           rev_in    = 4'h0;
  logic [3:0]           fwd_out, rev_out, exp_f, exp_r;
  logic                 iso_ok, above, short_c, sw_a, sw_b;
  logic [1:0]           mode;
  int                   bad_count = 0, check_count = 0, cycles = 0, ca, cb;
  // ****************************************
  // design and far side
  // ****************************************
  icrs_top #(.NCH(4), .SHUTDOWN_CNT(50), .PWM_MAX(8)) u_icrs_top (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .primary_supply_ok_i(prim_ok),
    .iso_supply_ok_i(iso_ok), .iso_above_start_i(above), .short_circuit_i(short_c),
    .peak_current_i(peak), .feedback_duty_i(duty), .fwd_data_i(fwd_in),
    .rev_data_i(rev_in), .fwd_data_o(fwd_out), .rev_data_o(rev_out),
    .primary_switch_a_o(sw_a), .primary_switch_b_o(sw_b), .conv_mode_o(mode));
  icrs_iso_model u_icrs_iso_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .charge_i(iso_en), .short_i(short_req), .iso_supply_ok_o(iso_ok),
    .iso_above_start_o(above), .short_circuit_o(short_c));
  // ****************************************
  // clock, timeout and helpers
  // ****************************************
  always #25 ref_clk_i = ~ref_clk_i;
  // a hang counts as a mismatch, then closes the run
  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 12000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end
  task automatic conclude;
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // sample mid-cycle so edge updates have landed
  task automatic settle;
    @(negedge ref_clk_i);
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // an output side shows its input only while it is powered
  function automatic logic [3:0] gated(input logic ok, input logic [3:0] v);
    return ok ? v : 4'h0;
  endfunction
  task automatic wait_mode(input logic [1:0] m, input int limit);
    for (int i = 0; i < limit && mode !== m; i++) @(negedge ref_clk_i);
    check("conv_mode", 8'(mode), 8'(m));
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(32'hF654));
    tick(10);
    reset_i <= 1'b0;
    fwd_in <= 4'hA;
    rev_in <= 4'h5;
    tick(30);
    settle;
    check("fwd_data_o", 8'(fwd_out), 8'h00);
    check("rev_data_o", 8'(rev_out), 8'h00);
    check("switches", 8'({sw_a, sw_b}), 8'h00);
    check("conv_mode", 8'(mode), 8'(ICRS_OFF));
    tick(1);
    prim_ok <= 1'b1;
    tick(3);
    settle;
    check("conv_mode", 8'(mode), 8'(ICRS_SOFT));
    tick(20);
    settle;
    check("fwd_data_o", 8'(fwd_out), 8'h00);
    check("rev_data_o", 8'(rev_out), 8'h00);
    tick(1);
    iso_en <= 1'b1;
    tick(30);
    settle;
    check("fwd_data_o", 8'(fwd_out), 8'(gated(iso_ok, 4'hA)));
    check("rev_data_o", 8'(rev_out), 8'h05);
    check("conv_mode", 8'(mode), 8'(ICRS_NORMAL));
    // random traffic, every fifth step with a one-cycle glitch first
    for (int i = 0; i < 40; i++) begin
      tick(1);
      exp_f = 4'($urandom);
      exp_r = 4'($urandom);
      if (i % 5 == 0) begin
        fwd_in <= ~exp_f;
        rev_in <= ~exp_r;
        tick(1);
      end
      fwd_in <= exp_f;
      rev_in <= exp_r;
      tick(4);
      settle;
      check("fwd_data_o", 8'(fwd_out), 8'(exp_f));
      check("rev_data_o", 8'(rev_out), 8'(exp_r));
    end
    tick(300);
    settle;
    check("fwd_data_o", 8'(fwd_out), 8'(exp_f));
    // switch on-time over two periods equals the feedback duty per switch
    for (int k = 0; k < 2; k++) begin
      tick(1);
      duty <= (k == 0) ? 8'h40 : 8'($urandom);
      tick(600);
      ca = 0;
      cb = 0;
      repeat (512) begin
        settle;
        ca += sw_a;
        cb += sw_b;
      end
      check("switch_a_on", 8'(ca), duty);
      check("switch_b_on", 8'(cb), duty);
    end
    tick(1);
    duty <= 8'hFF;
    tick(600);
    settle;
    for (int i = 0; i < 600 && !(sw_a | sw_b); i++) settle;
    tick(1);
    peak <= 1'b1;
    tick(1);
    settle;
    check("switches", 8'({sw_a, sw_b}), 8'h00);
    tick(3);
    settle;
    check("switches", 8'({sw_a, sw_b}), 8'h00);
    tick(1);
    peak <= 1'b0;
    short_req <= 1'b1;
    wait_mode(ICRS_SHUTDOWN, 5);
    tick(40);
    settle;
    check("conv_mode", 8'(mode), 8'(ICRS_SHUTDOWN));
    check("switches", 8'({sw_a, sw_b}), 8'h00);
    wait_mode(ICRS_SOFT, 15);
    tick(100);
    settle;
    check("conv_mode", 8'(mode), 8'(ICRS_SOFT));
    wait_mode(ICRS_SHUTDOWN, 40);
    tick(1);
    short_req <= 1'b0;
    wait_mode(ICRS_SOFT, 60);
    wait_mode(ICRS_NORMAL, 20);
    tick(1);
    fwd_in <= 4'hF;
    rev_in <= 4'hF;
    tick(40);
    prim_ok <= 1'b0;
    tick(60);
    settle;
    check("fwd_data_o", 8'(fwd_out), 8'h0F);
    check("rev_data_o", 8'(rev_out), 8'(gated(prim_ok, 4'hF)));
    check("switches", 8'({sw_a, sw_b}), 8'h00);
    tick(50);
    settle;
    check("fwd_data_o", 8'(fwd_out), 8'h00);
    conclude();
  end
endmodule // icrs_top_tb
